// file: hdl/lfs_pkg.sv
// constants for the linear frequency sweep block
package lfs_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // control_register_one
  localparam logic [7:0] OFS_LOWER  = 8'h04;  // lower_frequency_word
  localparam logic [7:0] OFS_UPPER  = 8'h08;  // upper_frequency_word
  localparam logic [7:0] OFS_RDELTA = 8'h0c;  // rising_delta_word
  localparam logic [7:0] OFS_FDELTA = 8'h10;  // falling_delta_word
  localparam logic [7:0] OFS_RRATE  = 8'h14;  // rising_ramp_rate_word
  localparam logic [7:0] OFS_FRATE  = 8'h18;  // falling_ramp_rate_word
  localparam logic [7:0] OFS_STATUS = 8'h1c;  // sweep state, read only
  localparam logic [7:0] OFS_FREQ   = 8'h20;  // live frequency word, read only

  // control register field positions
  localparam int EN_BIT     = 21;  // linear sweep enable
  localparam int RELOAD_BIT = 15;  // reload_rate_on_transfer
  localparam int NODWELL_BIT = 2;  // no-dwell

  // status register field positions
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_RISE_BIT   = 1;
  localparam int ST_FALL_BIT   = 2;
  localparam int ST_HOLD_BIT   = 3;
  localparam int ST_DIR_BIT    = 4;

  // reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [15:0] RST_RATE  = 16'h0001;

  // sync clock is the core clock divided by this
  localparam int SYNC_DIV = 4;
  localparam logic [1:0] SYNC_RISE_CNT = 2'h1;  // count just before sync clock rises

  // sweep states
  typedef enum logic [1:0] {
    ST_TONE = 2'b00,  // single tone, sweep disabled
    ST_RISE = 2'b01,
    ST_FALL = 2'b10,
    ST_HOLD = 2'b11   // parked at a terminal frequency
  } lfs_state_t;
endpackage

// file: hdl/lfs_ifs.sv
// interfaces between the sweep controller and its timer and sync divider
`timescale 1ns/1ns
interface lfs_tmr_if #(parameter int RATE_W = 16);
  logic              load;        // force a reload now
  logic [RATE_W-1:0] load_val;    // value for a forced reload
  logic [RATE_W-1:0] reload_val;  // value after a normal countdown
  logic              tick;        // count reached one
  modport ctl (output load, output load_val, output reload_val, input tick);
  modport tmr (input load, input load_val, input reload_val, output tick);
endinterface

interface lfs_sync_if;
  logic sync_clk;    // divided clock level
  logic xfer_pulse;  // one core cycle per strobe rising edge
  modport ctl (input sync_clk, input xfer_pulse);
  modport div (output sync_clk, output xfer_pulse);
endinterface

// file: hdl/lfs_ramp_timer.sv
// ramp rate countdown timer
`timescale 1ns/1ns
module lfs_ramp_timer #(
  parameter int RATE_W = 16
) (
  input  wire logic pclk,     // core clock
  input  wire logic presetn,  // async reset, low active
  input  wire logic ce,       // clock enable
  lfs_tmr_if.tmr    t         // controller side
);
  logic [RATE_W-1:0] count;

  // a rate of zero behaves as one so the sweep never stalls
  assign t.tick = !t.load && (count <= RATE_W'(1));

  // forced reloads win over the normal countdown, even mid count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= RATE_W'(1);
    end else if (ce) begin
      if (t.load) begin
        count <= t.load_val;
      end else if (count <= RATE_W'(1)) begin
        count <= t.reload_val;
      end else begin
        count <= count - RATE_W'(1);
      end
    end
  end
endmodule

// file: hdl/lfs_sync_div.sv
// sync clock divider and transfer strobe edge detector
`timescale 1ns/1ns
module lfs_sync_div (
  input  wire logic pclk,       // core clock
  input  wire logic presetn,    // async reset, low active
  input  wire logic ce,         // clock enable
  input  wire logic strobe_in,  // strobe, already synchronised
  lfs_sync_if.div   s           // controller side
);
  logic [1:0] cnt;
  logic       strobe_smp;

  // divide by four: low for two cycles, high for two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= 2'h0;
      s.sync_clk <= 1'b0;
    end else if (ce) begin
      cnt        <= cnt + 2'h1;
      s.sync_clk <= (cnt == lfs_pkg::SYNC_RISE_CNT) || (cnt == 2'h2);
    end
  end

  // strobe seen only at sync clock rising edges, then edge detected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_smp   <= 1'b0;
      s.xfer_pulse <= 1'b0;
    end else if (ce) begin
      if (cnt == lfs_pkg::SYNC_RISE_CNT) begin
        strobe_smp   <= strobe_in;
        s.xfer_pulse <= strobe_in && !strobe_smp;
      end else begin
        s.xfer_pulse <= 1'b0;
      end
    end
  end
endmodule

// file: hdl/lfs_top.sv
// linear frequency sweep controller with apb register access
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ns
// Operation
// - enable bit starts and stops linear sweep
// - direction high: rising rate, add rising delta
// - rising sweep stops at upper word
// - direction low: falling rate, subtract falling delta
// - falling sweep stops at lower word
// - dwell holds; no-dwell returns to lower word
// - only transfer strobe moves buffered registers
// - after reset single tone, sweep off
// - no-dwell: falling direction edge ignored
// - direction rise reloads rising rate now
// - reload bit: strobe reloads ramp timer
// - enabling sweep reloads ramp timer
// - strobe or enable reload picks rate by direction
// - strobe sampled on sync clock rise
// - sync clock is core clock over four
// - strobe edge detected into one pulse
module lfs_top #(
  parameter int RATE_W = 16  // ramp rate word width
) (
  input  wire logic        pclk,                      // core clock
  input  wire logic        presetn,                   // async reset, low active
  input  wire logic        ce,                        // clock enable, freezes all state
  input  wire logic        psel,                      // apb select
  input  wire logic        penable,                   // apb enable
  input  wire logic        pwrite,                    // apb direction
  input  wire logic [7:0]  paddr,                     // apb byte address
  input  wire logic [31:0] pwdata,                    // apb write data
  output logic      [31:0] prdata,                    // apb read data
  output logic             pready,                    // apb ready
  output logic             pslverr,                   // apb error, unmapped address
  input  wire logic        sweep_direction_pin,       // sweep direction
  input  wire logic        upper_profile_select_pin,  // must stay low while sweeping
  input  wire logic        transfer_strobe_pin,       // commits buffered writes
  output logic             sync_clk_out,              // divided clock for the controller
  output logic      [31:0] frequency_word,            // live tuning word
  output logic             sweep_active               // linear sweep enabled and profile pin low
);
  // buffered copies written by software
  logic [31:0]       buf_ctrl;
  logic [31:0]       buf_lower;
  logic [31:0]       buf_upper;
  logic [31:0]       buf_rdelta;
  logic [31:0]       buf_fdelta;
  logic [RATE_W-1:0] buf_rrate;
  logic [RATE_W-1:0] buf_frate;
  // active copies used by the sweep
  logic              sweep_en;
  logic              reload_on_xfer;
  logic              no_dwell;
  logic [31:0]       lower_frequency_word;
  logic [31:0]       upper_frequency_word;
  logic [31:0]       rising_delta_word;
  logic [31:0]       falling_delta_word;
  logic [RATE_W-1:0] rising_ramp_rate_word;
  logic [RATE_W-1:0] falling_ramp_rate_word;
  // pin synchronisers
  logic              dir_s1;
  logic              dir_s2;
  logic              dir_d;
  logic              strobe_s1;
  logic              strobe_s2;
  logic              prof_s1;
  logic              prof_s2;
  // sweep state
  lfs_pkg::lfs_state_t state;
  logic              en_d;
  logic [31:0]       acc;
  logic              dir_rise;
  logic              dir_fall;
  logic              en_rise;
  logic [32:0]       sum;
  logic [32:0]       diff;
  logic              apb_access;
  logic              apb_wr;
  logic              addr_ok;
  logic [31:0]       rd_mux;
  logic [31:0]       status_word;

  lfs_tmr_if #(.RATE_W(RATE_W)) tmr_bus ();
  lfs_sync_if sync_bus ();

  lfs_ramp_timer #(.RATE_W(RATE_W)) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .t       (tmr_bus.tmr)
  );

  lfs_sync_div u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .strobe_in (strobe_s2),
    .s         (sync_bus.div)
  );

  // two flops on every pin before any logic looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_s1    <= 1'b0;
      dir_s2    <= 1'b0;
      dir_d     <= 1'b0;
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      prof_s1   <= 1'b0;
      prof_s2   <= 1'b0;
    end else if (ce) begin
      dir_s1    <= sweep_direction_pin;
      dir_s2    <= dir_s1;
      dir_d     <= dir_s2;
      strobe_s1 <= transfer_strobe_pin;
      strobe_s2 <= strobe_s1;
      prof_s1   <= upper_profile_select_pin;
      prof_s2   <= prof_s1;
    end
  end

  // direction edges act in any sweep state, disabled sweep ignores them
  assign dir_rise = sweep_en && dir_s2 && !dir_d;
  assign dir_fall = sweep_en && !dir_s2 && dir_d;
  assign en_rise  = sweep_en && !en_d;

  // apb decode; ready comes one cycle into the access phase
  assign apb_access = psel && penable && !pready;
  assign apb_wr     = apb_access && pwrite && addr_ok;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      lfs_pkg::OFS_CTRL:   rd_mux = buf_ctrl;
      lfs_pkg::OFS_LOWER:  rd_mux = buf_lower;
      lfs_pkg::OFS_UPPER:  rd_mux = buf_upper;
      lfs_pkg::OFS_RDELTA: rd_mux = buf_rdelta;
      lfs_pkg::OFS_FDELTA: rd_mux = buf_fdelta;
      lfs_pkg::OFS_RRATE:  rd_mux = 32'(buf_rrate);
      lfs_pkg::OFS_FRATE:  rd_mux = 32'(buf_frate);
      lfs_pkg::OFS_STATUS: rd_mux = status_word;
      lfs_pkg::OFS_FREQ:   rd_mux = acc;
      default:             addr_ok = 1'b0;
    endcase
  end

  // status bits show the live sweep state and the seen direction level
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[lfs_pkg::ST_ACTIVE_BIT] = sweep_en;
    status_word[lfs_pkg::ST_RISE_BIT]   = (state == lfs_pkg::ST_RISE);
    status_word[lfs_pkg::ST_FALL_BIT]   = (state == lfs_pkg::ST_FALL);
    status_word[lfs_pkg::ST_HOLD_BIT]   = (state == lfs_pkg::ST_HOLD);
    status_word[lfs_pkg::ST_DIR_BIT]    = dir_s2;
  end

  // apb answer: read data, ready and error all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= apb_access;
      pslverr <= apb_access && !addr_ok;
      if (apb_access && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // software writes only land in the buffers; the sweep never sees them here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ctrl   <= lfs_pkg::RST_WORD;
      buf_lower  <= lfs_pkg::RST_WORD;
      buf_upper  <= lfs_pkg::RST_WORD;
      buf_rdelta <= lfs_pkg::RST_WORD;
      buf_fdelta <= lfs_pkg::RST_WORD;
      buf_rrate  <= RATE_W'(lfs_pkg::RST_RATE);
      buf_frate  <= RATE_W'(lfs_pkg::RST_RATE);
    end else if (ce && apb_wr) begin
      case (paddr)
        lfs_pkg::OFS_CTRL: begin
          buf_ctrl                      <= 32'h0000_0000;
          buf_ctrl[lfs_pkg::EN_BIT]     <= pwdata[lfs_pkg::EN_BIT];
          buf_ctrl[lfs_pkg::RELOAD_BIT] <= pwdata[lfs_pkg::RELOAD_BIT];
          buf_ctrl[lfs_pkg::NODWELL_BIT] <= pwdata[lfs_pkg::NODWELL_BIT];
        end
        lfs_pkg::OFS_LOWER:  buf_lower  <= pwdata;
        lfs_pkg::OFS_UPPER:  buf_upper  <= pwdata;
        lfs_pkg::OFS_RDELTA: buf_rdelta <= pwdata;
        lfs_pkg::OFS_FDELTA: buf_fdelta <= pwdata;
        lfs_pkg::OFS_RRATE:  buf_rrate  <= pwdata[RATE_W-1:0];
        lfs_pkg::OFS_FRATE:  buf_frate  <= pwdata[RATE_W-1:0];
        default: ;
      endcase
    end
  end

  // buffers move to the active set only on a strobe edge, never on direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweep_en               <= 1'b0;
      reload_on_xfer         <= 1'b0;
      no_dwell               <= 1'b0;
      lower_frequency_word   <= lfs_pkg::RST_WORD;
      upper_frequency_word   <= lfs_pkg::RST_WORD;
      rising_delta_word      <= lfs_pkg::RST_WORD;
      falling_delta_word     <= lfs_pkg::RST_WORD;
      rising_ramp_rate_word  <= RATE_W'(lfs_pkg::RST_RATE);
      falling_ramp_rate_word <= RATE_W'(lfs_pkg::RST_RATE);
      en_d                   <= 1'b0;
    end else if (ce) begin
      en_d <= sweep_en;
      if (sync_bus.xfer_pulse) begin
        sweep_en               <= buf_ctrl[lfs_pkg::EN_BIT];
        reload_on_xfer         <= buf_ctrl[lfs_pkg::RELOAD_BIT];
        no_dwell               <= buf_ctrl[lfs_pkg::NODWELL_BIT];
        lower_frequency_word   <= buf_lower;
        upper_frequency_word   <= buf_upper;
        rising_delta_word      <= buf_rdelta;
        falling_delta_word     <= buf_fdelta;
        rising_ramp_rate_word  <= buf_rrate;
        falling_ramp_rate_word <= buf_frate;
      end
    end
  end

  // timer reload: a direction edge wins, then the strobe, then the enable
  always_comb begin
    // no-dwell sweeps only rise, so a low pin must not slow them to the falling rate
    tmr_bus.reload_val = (dir_s2 || no_dwell) ? rising_ramp_rate_word
                                              : falling_ramp_rate_word;
    tmr_bus.load       = 1'b0;
    tmr_bus.load_val   = dir_s2 ? rising_ramp_rate_word : falling_ramp_rate_word;
    if (dir_rise) begin
      tmr_bus.load     = 1'b1;
      tmr_bus.load_val = rising_ramp_rate_word;
    end else if (dir_fall && !no_dwell) begin
      tmr_bus.load     = 1'b1;
      tmr_bus.load_val = falling_ramp_rate_word;
    end else if (sweep_en && reload_on_xfer && sync_bus.xfer_pulse) begin
      tmr_bus.load     = 1'b1;
    end else if (en_rise) begin
      tmr_bus.load     = 1'b1;
    end
  end

  // adder outputs carry one extra bit so wrap past the end is caught
  assign sum  = {1'b0, acc} + {1'b0, rising_delta_word};
  assign diff = {1'b0, acc} - {1'b0, falling_delta_word};

  // sweep state and frequency accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= lfs_pkg::ST_TONE;
      acc   <= lfs_pkg::RST_WORD;
    end else if (ce) begin
      case (state)
        lfs_pkg::ST_TONE: begin
          acc <= lower_frequency_word;  // single tone at the lower word
          if (sweep_en) begin
            state <= lfs_pkg::ST_HOLD;
          end
        end
        lfs_pkg::ST_RISE: begin
          if (!sweep_en) begin
            state <= lfs_pkg::ST_TONE;
          end else if (dir_rise && no_dwell) begin
            acc <= lower_frequency_word;
          end else if (dir_fall && !no_dwell) begin
            state <= lfs_pkg::ST_FALL;
          end else if (tmr_bus.tick) begin
            if (sum[32] || (sum[31:0] >= upper_frequency_word)) begin
              state <= lfs_pkg::ST_HOLD;
              acc   <= no_dwell ? lower_frequency_word : upper_frequency_word;
            end else begin
              acc <= sum[31:0];
            end
          end
        end
        lfs_pkg::ST_FALL: begin
          if (!sweep_en) begin
            state <= lfs_pkg::ST_TONE;
          end else if (dir_rise) begin
            state <= lfs_pkg::ST_RISE;
            if (no_dwell) begin
              acc <= lower_frequency_word;
            end
          end else if (no_dwell) begin
            state <= lfs_pkg::ST_HOLD;
          end else if (tmr_bus.tick) begin
            if (diff[32] || (diff[31:0] <= lower_frequency_word)) begin
              state <= lfs_pkg::ST_HOLD;
              acc   <= lower_frequency_word;
            end else begin
              acc <= diff[31:0];
            end
          end
        end
        lfs_pkg::ST_HOLD: begin
          // parked until a direction edge (a falling one is ignored under no-dwell) or until the sweep is disabled
          if (!sweep_en) begin
            state <= lfs_pkg::ST_TONE;
          end else if (dir_rise) begin
            state <= lfs_pkg::ST_RISE;
            if (no_dwell) begin
              acc <= lower_frequency_word;
            end
          end else if (dir_fall && !no_dwell) begin
            state <= lfs_pkg::ST_FALL;
          end
        end
        default: begin
          state <= lfs_pkg::ST_TONE;
        end
      endcase
    end
  end

  // registered outputs; the profile pin only gates sweep_active, never the sweep itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frequency_word <= lfs_pkg::RST_WORD;
      sweep_active   <= 1'b0;
      sync_clk_out   <= 1'b0;
    end else if (ce) begin
      frequency_word <= acc;
      sweep_active   <= sweep_en && !prof_s2;
      sync_clk_out   <= sync_bus.sync_clk;
    end
  end
endmodule

// file: hdl/lfs_unused_placeholder_none.sv
// intentionally no module: none
`timescale 1ns/1ns

// file: testbench/lfs_checker.sv
// port assertions for the sweep block
`timescale 1ns/1ns
module lfs_checker (
  input wire logic        pclk,                      // clock
  input wire logic        presetn,                   // reset
  input wire logic        ce,                        // enable
  input wire logic        psel,                      // apb
  input wire logic        penable,                   // apb
  input wire logic        pwrite,                    // apb
  input wire logic [7:0]  paddr,                     // apb
  input wire logic [31:0] pwdata,                    // apb
  input wire logic [31:0] prdata,                    // apb
  input wire logic        pready,                    // apb
  input wire logic        pslverr,                   // apb
  input wire logic        sweep_direction_pin,       // pin
  input wire logic        upper_profile_select_pin,  // pin
  input wire logic        transfer_strobe_pin,       // pin
  input wire logic        sync_clk_out,              // pin
  input wire logic [31:0] frequency_word,            // out
  input wire logic        sweep_active               // out
);
  logic       strobe_q;  // strobe last cycle
  logic [5:0] age;       // cycles since strobe rose
  // idle frequency may only move shortly after a strobe, so track its age
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b0;
      age      <= 6'h3f;
    end else begin
      strobe_q <= transfer_strobe_pin;
      if (transfer_strobe_pin && !strobe_q) begin
        age <= 6'h00;
      end else if (age != 6'h3f) begin
        age <= age + 6'h01;
      end
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sync_period_a: assert property ($rose(sync_clk_out) |=>
    sync_clk_out ##1 !sync_clk_out [*2] ##1 sync_clk_out) else $error("sync period");
  reset_tone_a: assert property ($rose(presetn) |->
    !sweep_active && frequency_word == 32'h0) else $error("not tone after reset");
  profile_gate_a: assert property (upper_profile_select_pin [*4] |-> !sweep_active)
    else $error("sweep with profile high");
  idle_commit_a: assert property (!sweep_active && $past(sweep_active) == 1'b0
    && $changed(frequency_word) |-> age < 6'h18) else $error("idle freq moved");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_pair_a: assert property (pslverr |-> pready) else $error("lone slverr");
  rdata_hold_a: assert property ($changed(prdata) |-> pready) else $error("prdata moved");
  ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without access");
  cover property ($rose(sweep_active));
  cover property ($fell(sweep_active));
  cover property (pslverr);
endmodule
bind lfs_top lfs_checker u_lfs_checker (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .sweep_direction_pin,
  .upper_profile_select_pin, .transfer_strobe_pin, .sync_clk_out, .frequency_word,
  .sweep_active);

// file: testbench/lfs_ctrl_model.sv
// stand-in for the external controller driving the sweep pins
`timescale 1ns/1ns
module lfs_ctrl_model (
  input  wire logic pclk,                      // clock
  input  wire logic presetn,                   // reset
  input  wire logic dir_cmd,                   // wanted direction
  input  wire logic prof_cmd,                  // wanted profile level
  input  wire logic upd_cmd,                   // request a strobe
  output logic      sweep_direction_pin,       // direction
  output logic      upper_profile_select_pin,  // profile
  output logic      transfer_strobe_pin        // commit strobe
);
  logic [3:0] cnt;  // strobe phase
  // six high then low until the next request, so the high time spans a full sync period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt                      <= 4'h0;
      transfer_strobe_pin      <= 1'b0;
      sweep_direction_pin      <= 1'b0;
      upper_profile_select_pin <= 1'b0;
    end else begin
      cnt                      <= upd_cmd ? 4'hc : cnt - 4'(cnt != 4'h0);
      transfer_strobe_pin      <= cnt > 4'h6;
      sweep_direction_pin      <= dir_cmd;
      upper_profile_select_pin <= prof_cmd;  // bench raises it only to test gating
    end
  end
endmodule

// file: testbench/testbench.sv
// self-checking bench for the linear sweep block
`timescale 1ns/1ns
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, frequency_word, st, rd, lo, hi, rdel, fdel;
  logic        sync_clk_out, sweep_active, dir_pin, prof_pin, strobe_pin;
  logic        dir_cmd, prof_cmd, upd_cmd, er, nd;
  logic [15:0] rrate, frate;
  int          fail_count, compares, cyc;
  lfs_top u_lfs_top (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sweep_direction_pin(dir_pin),
    .upper_profile_select_pin(prof_pin), .transfer_strobe_pin(strobe_pin),
    .sync_clk_out, .frequency_word, .sweep_active);
  lfs_ctrl_model u_lfs_ctrl_model (.pclk, .presetn, .dir_cmd, .prof_cmd, .upd_cmd,
    .sweep_direction_pin(dir_pin), .upper_profile_select_pin(prof_pin),
    .transfer_strobe_pin(strobe_pin));
  function automatic logic [27:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st[27:0];
  endfunction
  // next word after one tick; clamps at the terminal word, or returns to lo on a no-dwell rise
  function automatic logic [31:0] nxt(input logic [31:0] p, input logic up);
    logic [32:0] s;
    if (up) begin
      s = {1'b0, p} + {1'b0, rdel};
      return (s >= {1'b0, hi}) ? (nd ? lo : hi) : s[31:0];
    end
    s = {1'b0, p} - {1'b0, fdel};
    return (s[32] || s[31:0] <= lo) ? lo : s[31:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // the wait ends when pready is high, or at the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic upd();
    @(posedge pclk);
    upd_cmd <= 1'b1;
    @(posedge pclk);
    upd_cmd <= 1'b0;
    repeat (30) @(posedge pclk);
  endtask
  // follow up to n steps, checking each word and the spacing between steps
  task automatic sweep(input logic pin, input logic up, input int n, input logic fin);
    logic [31:0] prev;
    int          g;
    dir_cmd <= pin;
    prev = frequency_word;
    for (int k = 0; k < n; k++) begin
      g = 0;
      do begin
        @(posedge pclk);
        g++;
      end while (frequency_word === prev && g < 60);
      if (g == 60) break;
      chk(frequency_word, nxt(prev, up));
      if (k > 0) chk(32'(g), up ? 32'(rrate) : 32'(frate));
      prev = frequency_word;
    end
    if (fin) chk(frequency_word, (up && !nd) ? hi : lo);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, dir_cmd, prof_cmd, upd_cmd, nd} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    st = 32'h2ec5544e;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk(frequency_word, 32'h0);
    chk(32'(sweep_active), 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, (i > 4) ? 32'h1 : 32'h0);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk(32'(er), 32'h1);  // unmapped address refused
    lo = {4'h1, rnd()};
    hi = {4'h8, rnd()};
    rdel = {4'h1, rnd()};
    fdel = {4'h1, rnd()};
    rrate = 16'(6 + rnd() % 4);
    frate = 16'(2 + rnd() % 4);
    // start-up order: enable, deltas and rates, then the two words
    apb(1'b1, lfs_pkg::OFS_CTRL, 32'h1 << lfs_pkg::EN_BIT);
    apb(1'b1, lfs_pkg::OFS_RDELTA, rdel);
    apb(1'b1, lfs_pkg::OFS_FDELTA, fdel);
    apb(1'b1, lfs_pkg::OFS_RRATE, {16'h0, rrate});
    apb(1'b1, lfs_pkg::OFS_FRATE, {16'h0, frate});
    apb(1'b1, lfs_pkg::OFS_LOWER, lo);
    apb(1'b1, lfs_pkg::OFS_UPPER, hi);
    dir_cmd <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(frequency_word, 32'h0);
    dir_cmd <= 1'b0;
    upd();
    chk(frequency_word, lo);
    chk(32'(sweep_active), 32'h1);
    sweep(1'b1, 1'b1, 2, 1'b0);
    sweep(1'b0, 1'b0, 99, 1'b1);
    sweep(1'b1, 1'b1, 99, 1'b1);
    repeat (30) @(posedge pclk);
    chk(frequency_word, hi);
    sweep(1'b0, 1'b0, 99, 1'b1);
    prof_cmd <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'(sweep_active), 32'h0);
    prof_cmd <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(32'(sweep_active), 32'h1);
    nd = 1'b1;
    apb(1'b1, lfs_pkg::OFS_CTRL, 32'h1 << lfs_pkg::EN_BIT | 32'h1 << lfs_pkg::RELOAD_BIT
      | 32'h1 << lfs_pkg::NODWELL_BIT);
    upd();
    sweep(1'b1, 1'b1, 99, 1'b1);
    dir_cmd <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(frequency_word, lo);
    sweep(1'b1, 1'b1, 2, 1'b0);
    sweep(1'b0, 1'b1, 99, 1'b1);
    apb(1'b1, lfs_pkg::OFS_CTRL, 32'h0);
    upd();
    chk(32'(sweep_active), 32'h0);
    chk(frequency_word, lo);
    print_verdict();
  end
endmodule
